// [sic_i2c_port.sv]
`timescale 1ns/100ps
`default_nettype none
module sic_i2c_port
    import sic_pkg::*;
#(
    parameter int DEPTH = REG_BYTES
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic target_addr_strap_lo,
    input wire logic target_addr_strap_hi,
    input wire logic frameReflect,
    input wire logic [15:0] applyAddr,
    output logic [7:0] applyData,
    output logic frame_update_hold,
    output logic busy
);
    import sic_pkg::*;

    sic_bank_if bankBus ();

    sic_reg_bank #(
        .DEPTH(DEPTH)
    ) u_bank (
        .ref_clk(ref_clk),
        .srst(srst),
        .bus(bankBus)
    );

    // pin synchronisers; stage one feeds stage two only
    logic [3:0] pinMeta_q, pinMeta_d;
    logic [3:0] pinSync_q, pinSync_d;
    logic sclPrev_q, sclPrev_d;
    logic sdaPrev_q, sdaPrev_d;

    always_comb begin
        pinMeta_d = {target_addr_strap_hi, target_addr_strap_lo, sdaIn, sclIn};
        pinSync_d = pinMeta_q;
        sclPrev_d = pinSync_q[0];
        sdaPrev_d = pinSync_q[1];
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pinMeta_q <= 4'hF;
            pinSync_q <= 4'hF;
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            pinMeta_q <= pinMeta_d;
            pinSync_q <= pinSync_d;
            sclPrev_q <= sclPrev_d;
            sdaPrev_q <= sdaPrev_d;
        end
    end

    logic sclS, sdaS, sclRise, sclFall, startSeen, stopSeen;
    logic [6:0] myAddr;

    always_comb begin
        sclS = pinSync_q[0];
        sdaS = pinSync_q[1];
        sclRise = sclS && !sclPrev_q;
        sclFall = !sclS && sclPrev_q;
        startSeen = sclS && sclPrev_q && sdaPrev_q && !sdaS;
        stopSeen = sclS && sclPrev_q && !sdaPrev_q && sdaS;
        myAddr = sicTargetAddr(pinSync_q[3], pinSync_q[2]);
    end

    // link protocol state
    sic_state_type state_q, state_d;
    sic_ack_type ackKind_q, ackKind_d;
    logic [7:0] shift_q, shift_d;
    logic [2:0] bitCnt_q, bitCnt_d;
    logic [15:0] index_q, index_d;
    logic [7:0] addrHi_q, addrHi_d;
    logic ackOn_q, ackOn_d;
    logic loadPend_q, loadPend_d;
    logic oe_q, oe_d;
    logic wrEn_q, wrEn_d;
    logic [15:0] wrAddr_q, wrAddr_d;
    logic [7:0] wrData_q, wrData_d;

    always_comb begin
        state_d = state_q;
        ackKind_d = ackKind_q;
        shift_d = shift_q;
        bitCnt_d = bitCnt_q;
        index_d = index_q;
        addrHi_d = addrHi_q;
        ackOn_d = ackOn_q;
        loadPend_d = loadPend_q;
        oe_d = oe_q;
        wrEn_d = 1'b0;
        wrAddr_d = wrAddr_q;
        wrData_d = wrData_q;
        if (startSeen) begin
            // index survives both plain and repeated start
            state_d = ST_ADDR;
            bitCnt_d = 3'h0;
            ackOn_d = 1'b0;
            oe_d = 1'b0;
        end else if (stopSeen) begin
            state_d = ST_IDLE;
            oe_d = 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    oe_d = 1'b0;
                end
                ST_ADDR, ST_REGHI, ST_REGLO, ST_WDATA: begin
                    if (sclRise) begin
                        shift_d = {shift_q[6:0], sdaS};
                        bitCnt_d = bitCnt_q + 3'h1;
                        if (bitCnt_q == LAST_BIT) begin
                            state_d = ST_ACK;
                            ackOn_d = 1'b0;
                            case (state_q)
                                // direction bit is the one arriving on this rise
                                ST_ADDR: ackKind_d = sdaS ? AK_ADDRR : AK_ADDRW;
                                ST_REGHI: ackKind_d = AK_REGHI;
                                ST_REGLO: ackKind_d = AK_REGLO;
                                default: ackKind_d = AK_WDATA;
                            endcase
                            // foreign address: stay off the bus till next start
                            if (state_q == ST_ADDR && shift_q[6:0] != myAddr) begin
                                state_d = ST_IDLE;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (sclFall && !ackOn_q) begin
                        ackOn_d = 1'b1;
                        oe_d = 1'b1;
                        case (ackKind_q)
                            AK_REGHI: addrHi_d = shift_q;
                            AK_REGLO: index_d = {addrHi_q, shift_q};
                            AK_WDATA: begin
                                wrEn_d = 1'b1;
                                wrAddr_d = index_q;
                                wrData_d = shift_q;
                                index_d = index_q + 16'h0001;
                            end
                            default: ;
                        endcase
                    end else if (sclFall && ackOn_q) begin
                        ackOn_d = 1'b0;
                        bitCnt_d = 3'h0;
                        case (ackKind_q)
                            AK_ADDRR: begin
                                // bank read port already shows the current index
                                shift_d = bankBus.rdData;
                                oe_d = !bankBus.rdData[7];
                                state_d = ST_RDATA;
                            end
                            AK_ADDRW: begin
                                oe_d = 1'b0;
                                state_d = ST_REGHI;
                            end
                            AK_REGHI: begin
                                oe_d = 1'b0;
                                state_d = ST_REGLO;
                            end
                            default: begin
                                oe_d = 1'b0;
                                state_d = ST_WDATA;
                            end
                        endcase
                    end
                end
                ST_RDATA: begin
                    if (sclFall) begin
                        if (loadPend_q) begin
                            loadPend_d = 1'b0;
                            shift_d = bankBus.rdData;
                            oe_d = !bankBus.rdData[7];
                        end else begin
                            shift_d = {shift_q[6:0], 1'b0};
                            oe_d = !shift_q[6];
                        end
                    end else if (sclRise) begin
                        bitCnt_d = bitCnt_q + 3'h1;
                        if (bitCnt_q == LAST_BIT) begin
                            state_d = ST_MACK;
                        end
                    end
                end
                ST_MACK: begin
                    if (sclFall) begin
                        oe_d = 1'b0;
                    end else if (sclRise) begin
                        index_d = index_q + 16'h0001;
                        bitCnt_d = 3'h0;
                        if (!sdaS) begin
                            state_d = ST_RDATA;
                            loadPend_d = 1'b1;
                        end else begin
                            // nack: controller closes with a stop
                            state_d = ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            ackKind_q <= AK_ADDRW;
            shift_q <= 8'h00;
            bitCnt_q <= 3'h0;
            index_q <= INDEX_RESET;
            addrHi_q <= 8'h00;
            ackOn_q <= 1'b0;
            loadPend_q <= 1'b0;
            oe_q <= 1'b0;
            wrEn_q <= 1'b0;
            wrAddr_q <= 16'h0000;
            wrData_q <= 8'h00;
        end else begin
            state_q <= state_d;
            ackKind_q <= ackKind_d;
            shift_q <= shift_d;
            bitCnt_q <= bitCnt_d;
            index_q <= index_d;
            addrHi_q <= addrHi_d;
            ackOn_q <= ackOn_d;
            loadPend_q <= loadPend_d;
            oe_q <= oe_d;
            wrEn_q <= wrEn_d;
            wrAddr_q <= wrAddr_d;
            wrData_q <= wrData_d;
        end
    end

    // status outputs registered so every top output but the constant sdaOut leaves a flop
    logic hold_q, hold_d;
    logic busy_q, busy_d;

    always_comb begin
        hold_d = bankBus.holdBit;
        busy_d = (state_q != ST_IDLE);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hold_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            hold_q <= hold_d;
            busy_q <= busy_d;
        end
    end

    assign bankBus.wrEn = wrEn_q;
    assign bankBus.wrAddr = wrAddr_q;
    assign bankBus.wrData = wrData_q;
    assign bankBus.rdAddr = index_q;
    assign bankBus.frameTick = frameReflect;
    assign bankBus.applyAddr = applyAddr;

    // open drain: only ever pulls low
    assign sdaOut = 1'b0;
    assign sdaOe = oe_q;
    assign applyData = bankBus.applyData;
    assign frame_update_hold = hold_q;
    assign busy = busy_q;

endmodule // sic_i2c_port
`default_nettype wire

// [sic_pkg.sv]
package sic_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam logic [15:0] REG_BASE = 16'h3000;
    localparam int REG_BYTES = 4352;
    localparam logic [15:0] HOLD_ADDR = 16'h3001;
    localparam int HOLD_BIT = 0;
    localparam logic [15:0] FRAME_LO = 16'h3030;
    localparam logic [15:0] FRAME_HI = 16'h30FF;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] INDEX_RESET = 16'h0000;
    localparam logic [6:0] TADDR_LL = 7'h1A;
    localparam logic [6:0] TADDR_LH = 7'h10;
    localparam logic [6:0] TADDR_HL = 7'h36;
    localparam logic [6:0] TADDR_HH = 7'h37;
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_ADDR = 8'h02,
        ST_REGHI = 8'h04,
        ST_REGLO = 8'h08,
        ST_WDATA = 8'h10,
        ST_ACK = 8'h20,
        ST_RDATA = 8'h40,
        ST_MACK = 8'h80
    } sic_state_type;

    typedef enum logic [4:0] {
        AK_ADDRW = 5'h01,
        AK_ADDRR = 5'h02,
        AK_REGHI = 5'h04,
        AK_REGLO = 5'h08,
        AK_WDATA = 5'h10
    } sic_ack_type;

    function automatic logic [6:0] sicTargetAddr(input logic hi, input logic lo);
        case ({hi, lo})
            2'b00: sicTargetAddr = TADDR_LL;
            2'b01: sicTargetAddr = TADDR_LH;
            2'b10: sicTargetAddr = TADDR_HL;
            default: sicTargetAddr = TADDR_HH;
        endcase
    endfunction

    function automatic logic sicIsFrameClass(input logic [15:0] addr);
        sicIsFrameClass = (addr >= FRAME_LO) && (addr <= FRAME_HI);
    endfunction

endpackage

// [sic_bank_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface sic_bank_if;
    logic wrEn;
    logic [15:0] wrAddr;
    logic [7:0] wrData;
    logic [15:0] rdAddr;
    logic [7:0] rdData;
    logic frameTick;
    logic [15:0] applyAddr;
    logic [7:0] applyData;
    logic holdBit;

    modport bank (
        input wrEn, wrAddr, wrData, rdAddr, frameTick, applyAddr,
        output rdData, applyData, holdBit
    );
    modport port (
        output wrEn, wrAddr, wrData, rdAddr, frameTick, applyAddr,
        input rdData, applyData, holdBit
    );
endinterface
`default_nettype wire

// [sic_reg_bank.sv]
`timescale 1ns/100ps
`default_nettype none
module sic_reg_bank
    import sic_pkg::*;
#(
    parameter int DEPTH = REG_BYTES
) (
    input wire logic ref_clk,
    input wire logic srst,
    sic_bank_if.bank bus
);
    import sic_pkg::*;

    // hold register must sit inside the bank, and the bank inside the 16-bit map
    if (DEPTH < 2 || DEPTH > 32'h10000 - 32'(REG_BASE)) begin : g_depth_bad
        $error("sic_reg_bank: DEPTH out of range");
    end

    // written value, read back over the link
    logic [7:0] wrVal_q [DEPTH];
    logic [7:0] wrVal_d [DEPTH];
    // value in effect for the sensor core
    logic [7:0] actVal_q [DEPTH];
    logic [7:0] actVal_d [DEPTH];
    logic [7:0] rdData_q, rdData_d;
    logic [7:0] applyData_q, applyData_d;

    function automatic logic inBank(input logic [15:0] a);
        inBank = (a >= REG_BASE) && (32'(a - REG_BASE) < DEPTH);
    endfunction

    function automatic int slot(input logic [15:0] a);
        slot = int'(a - REG_BASE);
    endfunction

    always_comb begin
        wrVal_d = wrVal_q;
        actVal_d = actVal_q;
        // hold keeps the whole frame class frozen so a batch lands together
        if (bus.frameTick && !wrVal_q[slot(HOLD_ADDR)][HOLD_BIT]) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (sicIsFrameClass(16'(REG_BASE + 16'(i)))) begin
                    actVal_d[i] = wrVal_q[i];
                end
            end
        end
        // out-of-map writes are dropped silently
        if (bus.wrEn && inBank(bus.wrAddr)) begin
            wrVal_d[slot(bus.wrAddr)] = bus.wrData;
            if (!sicIsFrameClass(bus.wrAddr)) begin
                actVal_d[slot(bus.wrAddr)] = bus.wrData;
            end
        end
        rdData_d = inBank(bus.rdAddr) ? wrVal_q[slot(bus.rdAddr)] : REG_RESET;
        applyData_d = inBank(bus.applyAddr) ? actVal_q[slot(bus.applyAddr)] : REG_RESET;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int i = 0; i < DEPTH; i++) begin
                wrVal_q[i] <= REG_RESET;
                actVal_q[i] <= REG_RESET;
            end
            rdData_q <= REG_RESET;
            applyData_q <= REG_RESET;
        end else begin
            wrVal_q <= wrVal_d;
            actVal_q <= actVal_d;
            rdData_q <= rdData_d;
            applyData_q <= applyData_d;
        end
    end

    assign bus.rdData = rdData_q;
    assign bus.applyData = applyData_q;
    assign bus.holdBit = wrVal_q[slot(HOLD_ADDR)][HOLD_BIT];

endmodule // sic_reg_bank
`default_nettype wire

// [sic_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module sic_assertions
    import sic_pkg::*;
#(
    parameter int DEPTH = REG_BYTES
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic target_addr_strap_lo,
    input wire logic target_addr_strap_hi,
    input wire logic frameReflect,
    input wire logic [15:0] applyAddr,
    input wire logic [7:0] applyData,
    input wire logic frame_update_hold,
    input wire logic busy
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    logic inFrame;
    assign inFrame = applyAddr >= FRAME_LO && applyAddr <= FRAME_HI;
    sequence startSeq;
        $fell(sdaIn) && sclIn;
    endsequence
    sequence stopSeq;
        $rose(sdaIn) && sclIn;
    endsequence
    // applyData lags the address by one cycle, so it must be steady for two
    sequence addrHeld;
        inFrame && $past(applyAddr) == applyAddr && $past(applyAddr, 2) == applyAddr;
    endsequence
    property frameGated;
        addrHeld ##0 $changed(applyData) |->
            $past(frameReflect) || $past(frameReflect, 2) || $past(frameReflect, 3);
    endproperty
    property holdFreeze;
        frame_update_hold [*4] ##0 addrHeld |-> $stable(applyData);
    endproperty
    a_drive_low_only: assert property (sdaOut == 1'b0)
        else $error("sda driven high");
    a_start_busy: assert property (startSeq |-> ##[1:10] busy)
        else $error("start not taken");
    a_stop_idle: assert property (stopSeq |-> ##[1:10] !busy)
        else $error("stop not taken");
    a_oe_scl_low: assert property ($changed(sdaOe) |-> !sclIn && !$past(sclIn, 2))
        else $error("sda moved with scl high");
    a_oe_stands: assert property ($rose(sdaOe) |=> sdaOe [*8])
        else $error("sda drive too short");
    a_oe_in_txn: assert property (sdaOe |-> busy)
        else $error("sda driven while idle");
    a_hold_in_txn: assert property ($changed(frame_update_hold) |-> busy)
        else $error("hold moved outside a write");
    a_frame_gated: assert property (frameGated)
        else $error("frame register applied off the frame point");
    a_hold_freeze: assert property (holdFreeze)
        else $error("frame register applied under hold");
endmodule // sic_assertions
bind sic_i2c_port sic_assertions #(.DEPTH(DEPTH)) chk_u (
    .ref_clk(ref_clk), .srst(srst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .target_addr_strap_lo(target_addr_strap_lo),
    .target_addr_strap_hi(target_addr_strap_hi), .frameReflect(frameReflect),
    .applyAddr(applyAddr), .applyData(applyData),
    .frame_update_hold(frame_update_hold), .busy(busy)
);
`default_nettype wire

// [sic_ctrl_model.sv]
`timescale 1ns/100ps
`default_nettype none
module sic_ctrl_model (
    input wire logic sda,
    output logic scl,
    output logic sdaLow
);
    int extra = 0;
    // scl stands high between frames, sda released to the pull-up
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    task automatic bitIo(input logic b, output logic r);
        sdaLow = ~b;
        #(20 + extra) scl = 1'b1;
        #20 r = sda;
        #20 scl = 1'b0;
        #20;
    endtask
    // odd offset keeps scl edges off the ref_clk grid
    task automatic startC();
        #1.3 sdaLow = 1'b0;
        #20 scl = 1'b1;
        #20 sdaLow = 1'b1;
        #20 scl = 1'b0;
        #20;
    endtask
    task automatic stopC();
        sdaLow = 1'b1;
        #20 scl = 1'b1;
        #20 sdaLow = 1'b0;
        #40;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ackIn,
                        output logic [7:0] rx, output logic ackOut);
        for (int i = 7; i >= 0; i--) begin
            bitIo(tx[i], rx[i]);
        end
        bitIo(ackIn, ackOut);
    endtask
endmodule // sic_ctrl_model
`default_nettype wire

// [sic_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
    end \
end
module testbench;
    import sic_pkg::*;
    localparam int DEP = 64;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic strapLo = 1'b0;
    logic strapHi = 1'b0;
    logic frameReflect = 1'b0;
    logic [15:0] applyAddr = 16'h0000;
    logic scl;
    logic sdaLow;
    logic sdaOut;
    logic sdaOe;
    logic hold;
    logic busy;
    logic [7:0] applyData;
    wire logic sda;
    logic [7:0] mem [DEP];
    logic [7:0] app [DEP];
    logic [7:0] q[$];
    logic [15:0] idx;
    logic [31:0] rng = 32'h00011650;
    logic [6:0] ta;
    logic [7:0] rx;
    logic ak;
    int failures = 0;
    int total_checks = 0;
    assign sda = (sdaOe ? sdaOut : 1'b1) & ~sdaLow;
    always #2.5 ref_clk = ~ref_clk;
    sic_i2c_port #(.DEPTH(DEP)) dut_u (
        .ref_clk(ref_clk), .srst(srst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .target_addr_strap_lo(strapLo), .target_addr_strap_hi(strapHi),
        .frameReflect(frameReflect), .applyAddr(applyAddr), .applyData(applyData),
        .frame_update_hold(hold), .busy(busy)
    );
    sic_ctrl_model ctrl_u (.sda(sda), .scl(scl), .sdaLow(sdaLow));
    function automatic logic [7:0] rnd8();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[7:0];
    endfunction
    function automatic logic [6:0] expAddr(input logic [1:0] s);
        case (s)
            2'h0: return 7'h1A;
            2'h1: return 7'h10;
            2'h2: return 7'h36;
            default: return 7'h37;
        endcase
    endfunction
    function automatic logic inMap(input logic [15:0] a);
        return a >= 16'h3000 && a < 16'h3000 + DEP;
    endfunction
    function automatic logic [7:0] expRd(input logic [15:0] a);
        return inMap(a) ? mem[a - 16'h3000] : 8'h00;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic clr();
        foreach (mem[i]) begin
            mem[i] = 8'h00;
            app[i] = 8'h00;
        end
        idx = 16'h0000;
    endtask
    task automatic wbyte(input logic [7:0] b, input logic expNack);
        ctrl_u.xfer(b, 1'b1, rx, ak);
        `CHK("ack", expNack, ak)
    endtask
    task automatic stopI();
        int k;
        ctrl_u.stopC();
        for (k = 0; k < 20 && busy !== 1'b0; k++) begin
            tick(1);
        end
        `CHK("busy", 1'b0, busy)
        // a link that never goes idle ends the run here
        if (busy !== 1'b0) begin
            finish_test();
        end
    endtask
    task automatic addrPh(input logic [15:0] a);
        ctrl_u.startC();
        wbyte({ta, 1'b0}, 1'b0);
        wbyte(a[15:8], 1'b0);
        wbyte(a[7:0], 1'b0);
        idx = a;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d[$]);
        addrPh(a);
        foreach (d[i]) begin
            wbyte(d[i], 1'b0);
            if (inMap(idx)) begin
                mem[idx - 16'h3000] = d[i];
                if (idx < FRAME_LO || idx > FRAME_HI) app[idx - 16'h3000] = d[i];
            end
            idx++;
        end
        stopI();
    endtask
    task automatic rdN(input int n);
        ctrl_u.startC();
        wbyte({ta, 1'b1}, 1'b0);
        for (int i = 0; i < n; i++) begin
            ctrl_u.xfer(8'hFF, i == n - 1, rx, ak);
            `CHK("rdata", expRd(idx), rx)
            idx++;
        end
        stopI();
    endtask
    task automatic frame();
        frameReflect <= 1'b1;
        tick(1);
        frameReflect <= 1'b0;
        tick(4);
        if (mem[1][0] === 1'b0) begin
            for (int i = 8'h30; i < DEP; i++) app[i] = mem[i];
        end
    endtask
    task automatic chkAll();
        for (int i = 0; i < DEP; i++) begin
            applyAddr <= 16'h3000 + 16'(i);
            tick(3);
            `CHK("applied", app[i], applyData)
        end
        `CHK("hold", mem[1][0], hold)
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge ref_clk);
        failures++;
        finish_test();
    end
    initial begin
        clr();
        tick(5);
        srst <= 1'b0;
        tick(6);
        for (int s = 0; s < 4; s++) begin
            {strapHi, strapLo} <= 2'(s);
            tick(8);
            ta = expAddr(2'(s));
            ctrl_u.startC();
            wbyte({ta ^ 7'h01, 1'b0}, 1'b1);
            stopI();
            wr(16'h3010 + 16'(s), '{rnd8(), rnd8()});
            rdN(1);
        end
        for (int j = 0; j < 6; j++) begin
            ctrl_u.extra = (j % 2) * 40;
            q = {};
            repeat (1 + rnd8() % 4) q.push_back(rnd8());
            wr(16'h3002 + 16'(rnd8() % 62), q);
            chkAll();
        end
        ctrl_u.extra = 0;
        frame();
        chkAll();
        wr(16'h3001, '{8'h01});
        wr(16'h303E, '{8'hA5, 8'h5A});
        frame();
        chkAll();
        wr(16'h3001, '{8'h00});
        frame();
        chkAll();
        addrPh(16'h303E);
        rdN(3);
        addrPh(16'h302C);
        rdN(2);
        rdN(2);
        srst <= 1'b1;
        tick(3);
        srst <= 1'b0;
        clr();
        tick(6);
        rdN(1);
        chkAll();
        finish_test();
    end
endmodule // testbench
`default_nettype wire
